/* design/assp_pkg.sv */
// shared constants, types and helpers for the station serial framer
package assp_pkg;
  // control characters and the other character constants
  localparam logic [7:0] CH_SOH = 8'h01;
  localparam logic [7:0] CH_STX = 8'h02;
  localparam logic [7:0] CH_ETX = 8'h03;
  localparam logic [7:0] CH_EOT = 8'h04;
  localparam logic [7:0] CH_BCAST = 8'h2A;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_A_UP = 8'h41;
  localparam logic [7:0] CH_LOWER_OFS = 8'h20;
  localparam logic [7:0] CH_PRINT_MIN = 8'h20;
  localparam logic [7:0] CH_WRITE_MIN = 8'h38;

  // register byte offsets
  localparam logic [7:0] REG_CFG = 8'h00;
  localparam logic [7:0] REG_ACT = 8'h04;
  localparam logic [7:0] REG_IRQ_ST = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
  localparam logic [7:0] REG_STAT = 8'h10;

  // field positions
  localparam int CFG_BAUD_LSB = 0;
  localparam int CFG_DLY_BIT = 4;
  localparam int CFG_STN_LSB = 5;
  localparam int ACT_USB_BIT = 10;
  localparam int IRQ_REPLY_BIT = 0;
  localparam int IRQ_ERR_BIT = 1;
  localparam int IRQ_OK_BIT = 2;
  localparam int STAT_BUSY_BIT = 3;

  // reset values
  localparam logic [4:0] STN_RST = 5'h00;
  localparam logic DLY_RST = 1'b0;
  localparam logic [3:0] BAUD_RST = 4'h0;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;

  // timing
  localparam int RESP_DELAY_US = 800;
  localparam int CLK_MHZ = 125;
  localparam int RESP_DELAY_CYC = RESP_DELAY_US * CLK_MHZ;

  // answer codes, letter is 'A' plus the code, or 'a' plus it while alarm_i is high
  localparam logic [2:0] ERR_NORMAL = 3'h0;
  localparam logic [2:0] ERR_PARITY = 3'h1;
  localparam logic [2:0] ERR_CKSUM = 3'h2;
  localparam logic [2:0] ERR_CHAR = 3'h3;
  localparam logic [2:0] ERR_CMD = 3'h4;
  localparam logic [2:0] ERR_DATANO = 3'h5;

  // data field lengths by command class
  localparam logic [3:0] WR_DATA_CHARS = 4'h4;
  localparam logic [3:0] RD_DATA_CHARS = 4'h8;

  typedef struct packed {
    logic [4:0] station;
    logic delay;
    logic [3:0] baud;
  } assp_cfg_t;

  typedef struct packed {
    logic [15:0] cmd;
    logic [15:0] dno;
    logic [31:0] data;
    logic bcast;
  } assp_req_t;

  typedef struct packed {
    logic [2:0] code;
    logic [63:0] data;
  } assp_rsp_t;

  typedef struct packed {
    logic frame_ok;
    logic frame_err;
    logic reply_done;
  } assp_evt_t;

  // 0..9 then A..V
  function automatic logic [7:0] stn_char(input logic [4:0] stn);
    if (stn < 5'h0A) begin
      return CH_ZERO + {3'h0, stn};
    end
    return CH_A_UP + {3'h0, stn} - 8'h0A;
  endfunction

  function automatic logic [7:0] hex_char(input logic [3:0] nib);
    return stn_char({1'b0, nib});
  endfunction
endpackage

/* design/assp_regs.sv */
// wishbone register file, settings staging and interrupt logic
`timescale 1ns/1ns
module assp_regs (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic power_cycle_i,
  input wire logic usb_req_i,
  input wire assp_pkg::assp_evt_t evt_i,
  input wire logic busy_i,
  input wire logic [2:0] last_err_i,
  output assp_pkg::assp_cfg_t act_o,
  output logic usb_sel_o,
  output logic irq_o
);
  import assp_pkg::*;

  logic ack, next_ack;
  logic [31:0] rdat, next_rdat;
  assp_cfg_t cfg, next_cfg, act, next_act;
  logic usb_sel, next_usb_sel;
  logic [2:0] st, next_st, mask, next_mask;
  logic wr, rd;

  always_comb begin
    next_ack = wb_cyc_i & wb_stb_i & ~ack;
    // the access commits on the edge where ack is seen high
    wr = wb_cyc_i & wb_stb_i & ack & wb_we_i;
    rd = wb_cyc_i & wb_stb_i & ack & ~wb_we_i;
    next_cfg = cfg;
    next_mask = mask;
    if (wr && wb_adr_i == REG_CFG) begin
      if (wb_sel_i[0]) begin
        next_cfg[7:0] = wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        next_cfg[9:8] = wb_dat_i[9:8];
      end
    end
    if (wr && wb_adr_i == REG_IRQ_MASK && wb_sel_i[0]) begin
      next_mask = wb_dat_i[2:0];
    end
    // staged settings reach the link only at a power cycle
    next_act = power_cycle_i ? cfg : act;
    next_usb_sel = power_cycle_i ? usb_req_i : usb_sel;
    // only bits the read reported are cleared, so a late event is never lost
    next_st = (rd && wb_adr_i == REG_IRQ_ST) ? (st & ~rdat[2:0]) : st;
    next_st = next_st | evt_i;
    next_rdat = rdat;
    if (next_ack) begin
      unique case (wb_adr_i)
        REG_CFG: next_rdat = {22'h0, cfg};
        REG_ACT: next_rdat = {21'h0, usb_sel, act};
        REG_IRQ_ST: next_rdat = {29'h0, st};
        REG_IRQ_MASK: next_rdat = {29'h0, mask};
        REG_STAT: next_rdat = {28'h0, busy_i, last_err_i};
        default: next_rdat = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
      rdat <= 32'h0;
      cfg <= '{station: STN_RST, delay: DLY_RST, baud: BAUD_RST};
      act <= '{station: STN_RST, delay: DLY_RST, baud: BAUD_RST};
      usb_sel <= 1'b0;
      st <= 3'h0;
      mask <= IRQ_MASK_RST;
    end else begin
      ack <= next_ack;
      rdat <= next_rdat;
      cfg <= next_cfg;
      act <= next_act;
      usb_sel <= next_usb_sel;
      st <= next_st;
      mask <= next_mask;
    end
  end

  assign wb_ack_o = ack;
  assign wb_dat_o = rdat;
  assign act_o = act;
  assign usb_sel_o = usb_sel;
  assign irq_o = |(st & mask);
endmodule

/* design/assp_delay.sv */
// reply delay timer, done is a level once the wait has run out
`timescale 1ns/1ns
module assp_delay #(
  parameter int DELAY_CYCLES = assp_pkg::RESP_DELAY_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic long_i,
  output logic done_o
);
  import assp_pkg::*;

  localparam int CW = $clog2(DELAY_CYCLES + 1);
  logic [CW-1:0] cnt, next_cnt;

  always_comb begin
    next_cnt = cnt;
    if (start_i) begin
      next_cnt = long_i ? CW'(DELAY_CYCLES) : '0;
    end else if (cnt != '0) begin
      next_cnt = cnt - CW'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign done_o = (cnt == '0) & ~start_i;
endmodule

/* design/assp_top.sv */
// slave framer for the multidrop ascii command/response link
`timescale 1ns/1ns
module assp_top #(
  parameter int RESP_DELAY_CYCLES = assp_pkg::RESP_DELAY_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  input wire logic power_cycle_i,
  input wire logic usb_req_i,
  output logic usb_sel_o,
  output logic [3:0] baud_sel_o,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_perr_i,
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  output logic tx_en_o,
  input wire logic alarm_i,
  output assp_pkg::assp_req_t app_req_o,
  output logic app_req_valid_o,
  input wire assp_pkg::assp_rsp_t app_rsp_i,
  input wire logic app_rsp_valid_i
);
  import assp_pkg::*;

  typedef enum {
    S_IDLE, S_STN, S_CMD0, S_CMD1, S_STX, S_DNO0, S_DNO1,
    S_DATA, S_CS0, S_CS1, S_APP, S_WAIT, S_TX
  } assp_state_t;

  // write commands carry data, reads carry none but get a data reply when answered normally
  function automatic logic is_write(input logic [15:0] c);
    return c[15:8] >= CH_WRITE_MIN;
  endfunction

  function automatic logic [3:0] wr_len(input logic [15:0] c);
    return is_write(c) ? WR_DATA_CHARS : 4'h0;
  endfunction

  assp_state_t state, next_state;
  assp_cfg_t act;
  assp_evt_t evt;
  logic [7:0] sum, next_sum, cs_hi, next_cs_hi;
  logic hit, next_hit, bcast, next_bcast;
  logic perr, next_perr, cerr, next_cerr;
  logic [15:0] cmd, next_cmd, dno, next_dno;
  logic [31:0] data, next_data;
  logic [3:0] dcnt, next_dcnt, rsp_len, next_rsp_len;
  logic [2:0] code, next_code;
  logic reply, next_reply;
  logic [63:0] rsp, next_rsp;
  logic [3:0] tx_idx, next_tx_idx;
  logic [7:0] tx_sum, next_tx_sum, tx_data, next_tx_data, tx_byte;
  logic tx_valid, next_tx_valid;
  logic req_valid, next_req_valid;
  logic usb_sel, rx_ok, tmr_start, tmr_done, c_ok;
  logic [7:0] own_char, rx_sum;

  assp_regs u_regs (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .power_cycle_i(power_cycle_i),
    .usb_req_i(usb_req_i),
    .evt_i(evt),
    .busy_i(state != S_IDLE),
    .last_err_i(code),
    .act_o(act),
    .usb_sel_o(usb_sel),
    .irq_o(irq_o)
  );

  assp_delay #(
    .DELAY_CYCLES(RESP_DELAY_CYCLES)
  ) u_delay (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(tmr_start),
    .long_i(act.delay),
    .done_o(tmr_done)
  );

  always_comb begin
    own_char = stn_char(act.station);
    rx_ok = rx_valid_i & ~usb_sel;
    rx_sum = sum + rx_data_i;
    c_ok = (cs_hi == hex_char(sum[7:4])) && (rx_data_i == hex_char(sum[3:0]));
    // reply byte chosen by position: STX, station, letter, data, ETX, check
    if (tx_idx == 4'h0) begin
      tx_byte = CH_STX;
    end else if (tx_idx == 4'h1) begin
      tx_byte = own_char;
    end else if (tx_idx == 4'h2) begin
      tx_byte = CH_A_UP + {5'h0, code} + (alarm_i ? CH_LOWER_OFS : 8'h00);
    end else if (tx_idx < rsp_len + 4'h3) begin
      tx_byte = rsp[63:56];
    end else if (tx_idx == rsp_len + 4'h3) begin
      tx_byte = CH_ETX;
    end else if (tx_idx == rsp_len + 4'h4) begin
      tx_byte = hex_char(tx_sum[7:4]);
    end else begin
      tx_byte = hex_char(tx_sum[3:0]);
    end
  end

  always_comb begin
    next_state = state;
    next_sum = sum;
    next_cs_hi = cs_hi;
    next_hit = hit;
    next_bcast = bcast;
    next_perr = perr;
    next_cerr = cerr;
    next_cmd = cmd;
    next_dno = dno;
    next_data = data;
    next_dcnt = dcnt;
    next_rsp_len = rsp_len;
    next_code = code;
    next_reply = reply;
    next_rsp = rsp;
    next_tx_idx = tx_idx;
    next_tx_sum = tx_sum;
    next_tx_data = tx_data;
    next_tx_valid = tx_valid;
    next_req_valid = 1'b0;
    tmr_start = 1'b0;
    evt = '0;
    if (state inside {S_APP, S_WAIT, S_TX}) begin
      // half duplex: receive is deaf while a reply is pending
    end else if (rx_ok && rx_data_i == CH_EOT) begin
      next_state = S_IDLE;
    end else if (rx_ok && rx_data_i == CH_SOH) begin
      next_state = S_STN;
      next_sum = 8'h00;
      next_perr = 1'b0;
      next_cerr = 1'b0;
    end else if (rx_ok && state != S_IDLE) begin
      next_sum = rx_sum;
      next_perr = perr | rx_perr_i;
      next_cerr = cerr | rx_data_i[7];
      unique case (state)
        S_STN: begin
          next_hit = rx_data_i == own_char;
          next_bcast = rx_data_i == CH_BCAST;
          next_state = (next_hit | next_bcast) ? S_CMD0 : S_IDLE;
        end
        S_CMD0: begin
          next_cmd[15:8] = rx_data_i;
          next_state = S_CMD1;
        end
        S_CMD1: begin
          next_cmd[7:0] = rx_data_i;
          next_state = S_STX;
        end
        S_STX: begin
          next_cerr = next_cerr | (rx_data_i != CH_STX);
          next_state = S_DNO0;
        end
        S_DNO0: begin
          next_dno[15:8] = rx_data_i;
          next_state = S_DNO1;
        end
        S_DNO1: begin
          next_dno[7:0] = rx_data_i;
          next_dcnt = 4'h0;
          next_data = 32'h0;
          next_state = S_DATA;
        end
        S_DATA: begin
          if (rx_data_i == CH_ETX) begin
            next_cerr = next_cerr | (dcnt != wr_len(cmd));
            next_state = S_CS0;
          end else begin
            next_cerr = next_cerr | (rx_data_i < CH_PRINT_MIN);
            if (dcnt < WR_DATA_CHARS) begin
              next_data = {data[23:0], rx_data_i};
            end
            if (dcnt != 4'hF) begin
              next_dcnt = dcnt + 4'h1;
            end
          end
        end
        S_CS0: begin
          next_sum = sum;
          next_cs_hi = rx_data_i;
          next_state = S_CS1;
        end
        S_CS1: begin
          next_sum = sum;
          // parity before check before character errors
          next_code = next_perr ? ERR_PARITY :
                      !c_ok ? ERR_CKSUM :
                      next_cerr ? ERR_CHAR : ERR_NORMAL;
          next_reply = hit | (bcast & (act.station == 5'h00));
          next_rsp_len = 4'h0;
          tmr_start = 1'b1;
          if (next_code == ERR_NORMAL) begin
            evt.frame_ok = 1'b1;
            next_req_valid = 1'b1;
            next_state = S_APP;
          end else begin
            evt.frame_err = 1'b1;
            next_state = next_reply ? S_WAIT : S_IDLE;
          end
        end
        default: next_state = S_IDLE;
      endcase
    end
    unique case (state)
      S_APP: begin
        if (app_rsp_valid_i) begin
          next_code = app_rsp_i.code;
          next_rsp = app_rsp_i.data;
          // normal reads answer with a data field, writes and error answers with the letter only
          next_rsp_len = (app_rsp_i.code == ERR_NORMAL && !is_write(cmd)) ?
                         RD_DATA_CHARS : 4'h0;
          next_state = reply ? S_WAIT : S_IDLE;
        end
      end
      S_WAIT: begin
        if (tmr_done) begin
          next_state = S_TX;
          next_tx_idx = 4'h0;
          next_tx_sum = 8'h00;
        end
      end
      S_TX: begin
        if (!tx_valid || tx_ready_i) begin
          if (tx_idx == rsp_len + 4'h6) begin
            next_tx_valid = 1'b0;
            next_state = S_IDLE;
            evt.reply_done = 1'b1;
          end else begin
            next_tx_valid = 1'b1;
            next_tx_data = tx_byte;
            next_tx_idx = tx_idx + 4'h1;
            if (tx_idx != 4'h0 && tx_idx <= rsp_len + 4'h3) begin
              next_tx_sum = tx_sum + tx_byte;
            end
            if (tx_idx > 4'h2 && tx_idx < rsp_len + 4'h3) begin
              next_rsp = {rsp[55:0], 8'h00};
            end
          end
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= S_IDLE;
      sum <= 8'h00;
      cs_hi <= 8'h00;
      hit <= 1'b0;
      bcast <= 1'b0;
      perr <= 1'b0;
      cerr <= 1'b0;
      cmd <= 16'h0;
      dno <= 16'h0;
      data <= 32'h0;
      dcnt <= 4'h0;
      rsp_len <= 4'h0;
      code <= ERR_NORMAL;
      reply <= 1'b0;
      rsp <= 64'h0;
      tx_idx <= 4'h0;
      tx_sum <= 8'h00;
      tx_data <= 8'h00;
      tx_valid <= 1'b0;
      req_valid <= 1'b0;
    end else begin
      state <= next_state;
      sum <= next_sum;
      cs_hi <= next_cs_hi;
      hit <= next_hit;
      bcast <= next_bcast;
      perr <= next_perr;
      cerr <= next_cerr;
      cmd <= next_cmd;
      dno <= next_dno;
      data <= next_data;
      dcnt <= next_dcnt;
      rsp_len <= next_rsp_len;
      code <= next_code;
      reply <= next_reply;
      rsp <= next_rsp;
      tx_idx <= next_tx_idx;
      tx_sum <= next_tx_sum;
      tx_data <= next_tx_data;
      tx_valid <= next_tx_valid;
      req_valid <= next_req_valid;
    end
  end

  assign baud_sel_o = act.baud;
  assign usb_sel_o = usb_sel;
  assign tx_valid_o = tx_valid;
  assign tx_data_o = tx_data;
  assign tx_en_o = state == S_TX;
  assign app_req_o = '{cmd: cmd, dno: dno, data: data, bcast: bcast};
  assign app_req_valid_o = req_valid;
endmodule

/* sim/assp_top_sva.sv */
// port-level assertions for the station framer
`timescale 1ns/1ns
module assp_top_sva import assp_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic irq_o,
  input wire logic power_cycle_i,
  input wire logic usb_sel_o,
  input wire logic [3:0] baud_sel_o,
  input wire logic tx_valid_o,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  input wire logic tx_en_o,
  input wire logic app_req_valid_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_after_req_a:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus answer missing one cycle after request");
  ack_single_a:
    assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus answer longer than one cycle");
  tx_byte_hold_a:
    assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("reply byte changed before it was taken");
  tx_ascii_a:
    assert property (tx_valid_o |-> !tx_data_o[7])
    else $error("reply byte with top bit set");
  usb_silent_a:
    assert property (usb_sel_o |-> !tx_en_o)
    else $error("serial driver enabled while usb selected");
  power_settle_a:
    assert property ($changed(baud_sel_o) || $changed(usb_sel_o) |-> $past(power_cycle_i))
    else $error("active setting changed without power cycle");
  reply_opens_stx_a:
    assert property ($rose(tx_en_o) |-> ##[0:3] (tx_valid_o && tx_data_o == CH_STX))
    else $error("reply does not open with start of text");
  irq_clear_bus_a:
    assert property ($fell(irq_o) |-> $past(wb_ack_o))
    else $error("interrupt dropped without a bus access");
  req_pulse_a:
    assert property (app_req_valid_o |=> !app_req_valid_o)
    else $error("request strobe longer than one cycle");
endmodule

bind assp_top assp_top_sva u_sva (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .irq_o(irq_o), .power_cycle_i(power_cycle_i),
  .usb_sel_o(usb_sel_o), .baud_sel_o(baud_sel_o), .tx_valid_o(tx_valid_o),
  .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i), .tx_en_o(tx_en_o),
  .app_req_valid_o(app_req_valid_o)
);

/* sim/assp_master_model.sv */
// master station model: sends frame bytes, collects reply bytes
`timescale 1ns/1ns
module assp_master_model (
  input wire logic clk_i,
  input wire logic slow_i,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic rx_perr_o,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  output logic tx_ready_o
);
  logic [7:0] got[$];
  logic [1:0] ph = 2'h0;
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o = 8'h00;
    rx_perr_o = 1'b0;
  end
  // a slow master is ready one cycle in four
  assign tx_ready_o = !slow_i || (ph == 2'h3);
  always @(posedge clk_i) begin
    ph <= ph + 2'h1;
    if (tx_valid_i && tx_ready_o) begin
      got.push_back(tx_data_i);
    end
  end
  // same baud is implied by the byte-level link
  task automatic send(input logic [7:0] b);
    @(posedge clk_i);
    rx_valid_o <= 1'b1;
    rx_data_o <= b;
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    // idle line never repeats the last byte
    rx_data_o <= ~b;
  endtask
endmodule

/* sim/testbench.sv */
// self-checking bench for the station framer
`timescale 1ns/1ns
module testbench;
  import assp_pkg::*;
  localparam int DLY = 20;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic power_cycle_i = 1'b0;
  logic usb_req_i = 1'b0;
  logic alarm_i = 1'b0;
  logic slow = 1'b0;
  logic app_rsp_valid_i = 1'b0;
  assp_rsp_t app_rsp_i = '0;
  assp_req_t app_req_o;
  logic [31:0] wb_dat_o, rd;
  logic [3:0] baud_sel_o;
  logic [7:0] rx_data_i, tx_data_o;
  logic wb_ack_o, irq_o, usb_sel_o, tx_valid_o, tx_en_o, app_req_valid_o;
  logic rx_valid_i, rx_perr_i, tx_ready_i;
  int failures = 0;
  int checked = 0;
  int cyc = 0;
  int t0, t1;
  logic [15:0] fcmd;
  logic [31:0] fdat;
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) cyc <= cyc + 1;

  assp_top #(.RESP_DELAY_CYCLES(DLY)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
    .power_cycle_i(power_cycle_i), .usb_req_i(usb_req_i), .usb_sel_o(usb_sel_o),
    .baud_sel_o(baud_sel_o), .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i),
    .rx_perr_i(rx_perr_i), .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o),
    .tx_ready_i(tx_ready_i), .tx_en_o(tx_en_o), .alarm_i(alarm_i),
    .app_req_o(app_req_o), .app_req_valid_o(app_req_valid_o),
    .app_rsp_i(app_rsp_i), .app_rsp_valid_i(app_rsp_valid_i));
  assp_master_model u_master (
    .clk_i(clk_i), .slow_i(slow), .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i),
    .rx_perr_o(rx_perr_i), .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o),
    .tx_ready_o(tx_ready_i));

  task automatic conclude();
    if (failures == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic hang();
    failures++;
    conclude();
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) hang();
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic pcycle(input logic usb);
    @(posedge clk_i);
    usb_req_i <= usb;
    power_cycle_i <= 1'b1;
    @(posedge clk_i);
    power_cycle_i <= 1'b0;
    @(posedge clk_i);
  endtask
  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
  endfunction
  // read 01 or write 84 with four data chars, data number 00; bad flips the check
  task automatic frame(input logic [7:0] st, input logic [7:0] bad, input bit w);
    logic [7:0] b[$];
    logic [7:0] s;
    fcmd = w ? 16'h3834 : 16'h3031;
    fdat = w ? 32'h31323334 : 32'h0;
    b = '{st, fcmd[15:8], fcmd[7:0], CH_STX, 8'h30, 8'h30};
    if (w) b = {b, 8'h31, 8'h32, 8'h33, 8'h34};
    b.push_back(CH_ETX);
    s = 8'h00;
    foreach (b[i]) s += b[i];
    s ^= bad;
    u_master.send(CH_SOH);
    foreach (b[i]) u_master.send(b[i]);
    u_master.send(hx(s[7:4]));
    u_master.send(hx(s[3:0]));
    t0 = cyc;
  endtask
  task automatic serve(input logic bc);
    int n;
    n = 0;
    while (app_req_valid_o !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 200) hang();
    cmp(32'(app_req_o.cmd), 32'(fcmd));
    cmp(32'(app_req_o.dno), 32'h3030);
    cmp(app_req_o.data, fdat);
    cmp(32'(app_req_o.bcast), 32'(bc));
    app_rsp_i <= '{ERR_NORMAL, 64'h3031323341424344};
    app_rsp_valid_i <= 1'b1;
    @(posedge clk_i);
    app_rsp_valid_i <= 1'b0;
  endtask
  task automatic reply(input logic [7:0] st, input logic [7:0] lt, input bit dat);
    logic [7:0] e[$];
    logic [7:0] s;
    int n;
    e = '{st, lt};
    if (dat) e = {e, 8'h30, 8'h31, 8'h32, 8'h33, 8'h41, 8'h42, 8'h43, 8'h44};
    e.push_back(CH_ETX);
    s = 8'h00;
    foreach (e[i]) s += e[i];
    e.push_back(hx(s[7:4]));
    e.push_back(hx(s[3:0]));
    e.push_front(CH_STX);
    n = 0;
    t1 = cyc;
    while (u_master.got.size() < e.size() && n < 2000) begin
      @(posedge clk_i);
      n++;
      if (u_master.got.size() == 0) t1 = cyc;
    end
    if (n >= 2000) hang();
    repeat (20) @(posedge clk_i);
    cmp(u_master.got.size(), e.size());
    foreach (e[i]) cmp(u_master.got[i], e[i]);
    u_master.got.delete();
  endtask
  task automatic quiet();
    repeat (60) @(posedge clk_i);
    cmp(u_master.got.size(), 0);
  endtask

  task automatic scn_cfg();
    wb(1'b1, REG_CFG, 32'h205);
    wb(1'b0, REG_ACT, 32'h0);
    cmp(rd, 32'h0);
    pcycle(1'b0);
    wb(1'b0, REG_ACT, 32'h0);
    cmp(rd, 32'h205);
    cmp(32'(baud_sel_o), 32'h5);
    wb(1'b0, 8'h40, 32'h0);
    cmp(rd, 32'h0);
  endtask
  task automatic scn_own();
    @(posedge clk_i);
    alarm_i <= 1'b1;
    slow <= 1'b1;
    frame(8'h47, 8'h00, 1'b0);
    serve(1'b0);
    reply(8'h47, 8'h61, 1'b1);
    cmp(32'(t1 - t0 < DLY), 32'h1);
    alarm_i <= 1'b0;
    slow <= 1'b0;
  endtask
  task automatic scn_others();
    logic [7:0] tl[$];
    tl = '{8'h30, 8'h31, CH_STX, 8'h30, 8'h30, CH_ETX, 8'h30, 8'h30};
    frame(8'h48, 8'h00, 1'b0);
    quiet();
    // aborted frame: the tail after end of transmission must be ignored
    u_master.send(CH_SOH);
    u_master.send(8'h47);
    u_master.send(CH_EOT);
    foreach (tl[i]) u_master.send(tl[i]);
    quiet();
    frame(8'h47, 8'h00, 1'b1);
    serve(1'b0);
    reply(8'h47, 8'h41, 1'b0);
    frame(CH_BCAST, 8'h00, 1'b0);
    serve(1'b1);
    quiet();
  endtask
  task automatic scn_err_irq();
    wb(1'b0, REG_IRQ_ST, 32'h0);
    wb(1'b1, REG_IRQ_MASK, 32'h2);
    wb(1'b0, REG_IRQ_MASK, 32'h0);
    cmp(rd, 32'h2);
    frame(8'h47, 8'h01, 1'b0);
    reply(8'h47, 8'h43, 1'b0);
    cmp(32'(irq_o), 32'h1);
    wb(1'b0, REG_STAT, 32'h0);
    cmp(rd, 32'h2);
    wb(1'b0, REG_IRQ_ST, 32'h0);
    cmp(rd, 32'h3);
    @(posedge clk_i);
    cmp(32'(irq_o), 32'h0);
  endtask
  task automatic scn_usb();
    pcycle(1'b1);
    cmp(32'(usb_sel_o), 32'h1);
    frame(8'h47, 8'h00, 1'b0);
    quiet();
    pcycle(1'b0);
  endtask
  task automatic scn_stn0();
    wb(1'b1, REG_CFG, 32'h015);
    pcycle(1'b0);
    frame(CH_BCAST, 8'h00, 1'b0);
    serve(1'b1);
    reply(CH_ZERO, 8'h41, 1'b1);
    cmp(32'(t1 - t0 >= DLY), 32'h1);
  endtask

  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    scn_cfg();
    scn_own();
    scn_others();
    scn_err_irq();
    scn_usb();
    scn_stn0();
    conclude();
  end
endmodule
